// ---- core/phy_event_pkg.sv ----
// constants and carrier types of the link event counter log unit
// Function
// - count data frames received and refused
// - count refused non-data frames, both directions
// - count sent non-data frames refused by host
// - count received non-data frames we refused
// - count every not-ready to ready transition
// - power-management transitions may also count
// - count acknowledged reset-signature frames after link reset
// - count received frames refused for CRC
// - count received frames refused, other causes
// - report is exactly one 512-byte page
// - reserved bytes read as zero
// - entry is 16-bit identifier then value
// - zero identifier ends list, nothing after
// - value width from identifier bits 14:12
// - narrow saturated counter one-extended upward
// - counters saturate, never wrap
// - last byte makes page sum zero
// - width codes 1 to 4 mean 16..64
// - bit 15 marks vendor counters
// - clear on self-test frame or read flag
// - counters survive link and software reset
package phy_event_pkg;
   localparam int NUM_CNT      = 8;
   localparam int CNT_BITS     = 16;
   localparam int ENTRY_BYTES  = 6;
   localparam int PAGE_BYTES   = 512;
   localparam int HDR_BYTES    = 4;
   localparam int LIST_END     = HDR_BYTES + NUM_CNT * ENTRY_BYTES;
   localparam int TERM_END     = LIST_END + 2;
   localparam logic [9:0] LAST_BYTE = 10'h1FF;
   localparam logic [2:0] SIZE_CODE_32 = 3'h2;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [11:0] CODE_LIST [NUM_CNT] = '{
      12'h004, 12'h005, 12'h006, 12'h007, 12'h009, 12'h00A, 12'h00B, 12'h00D};

   typedef struct packed {
      logic h2d_data_err;
      logic d2h_nondata_err;
      logic h2d_nondata_err;
      logic phy_ready;
      logic pm_transition;
      logic sig_fis_ok;
      logic h2d_crc_err;
      logic h2d_other_err;
   } link_events_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } page_byte_t;
endpackage

// ---- core/sat_counter.sv ----
// one saturating event counter with clear
`timescale 1ns/100ps
`default_nettype none
module sat_counter (
   input  wire logic                              core_clk,
   input  wire logic                              resetn,
   input  wire logic                              clk_en,
   input  wire logic                              clear,
   input  wire logic                              inc,
   output logic [phy_event_pkg::CNT_BITS-1:0]     value
);
   typedef struct packed {
      logic [phy_event_pkg::CNT_BITS-1:0] cnt;
   } sat_state_t;
   sat_state_t st;
   sat_state_t next_st;

   always_comb begin
      next_st = st;
      if (clear) begin
         next_st.cnt = phy_event_pkg::CNT_RESET;
         if (inc) begin
            next_st.cnt = 16'h0001;
         end
      end else if (inc && !(&st.cnt)) begin
         next_st.cnt = st.cnt + 16'h0001;
      end
   end

   // only power-up reset and the clear input zero the count; link and software resets never reach here
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st.cnt <= phy_event_pkg::CNT_RESET;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign value = st.cnt;
endmodule
`default_nettype wire

// ---- core/phy_event_counter_log.sv ----
// link event counters and log page serialiser
`timescale 1ns/100ps
`default_nettype none
module phy_event_counter_log (
   input  wire logic                        core_clk,
   input  wire logic                        resetn,
   input  wire logic                        clk_en,
   input  wire phy_event_pkg::link_events_t events,
   input  wire logic                        pm_enabled,
   input  wire logic                        selftest_rx,
   input  wire logic                        read_req,
   input  wire logic                        read_clear,
   input  wire logic                        page_ready,
   output phy_event_pkg::page_byte_t        page_out,
   output logic                             busy
);
   typedef enum logic [1:0] {IDLE, SEND, DONE} phase_t;

   typedef struct packed {
      phase_t     phase;
      logic [9:0] idx;
      logic [7:0] sum;
      logic       clr_after;
      logic       ready_d;
      phy_event_pkg::page_byte_t out;
   } log_state_t;

   log_state_t st;
   log_state_t next_st;

   logic [phy_event_pkg::NUM_CNT-1:0] inc;
   logic [phy_event_pkg::CNT_BITS-1:0] cnt_val [phy_event_pkg::NUM_CNT];
   logic clear_all;
   logic [7:0] cur_byte;
   logic ready_rise;

   ////////////////////////////////////////////////////////////////////////////
   // event decode

   // rising edge of ready level; pm wakes only count when enabled
   assign ready_rise = events.phy_ready && !st.ready_d;

   always_comb begin
      inc[0] = events.h2d_data_err;
      inc[1] = events.d2h_nondata_err || events.h2d_nondata_err;
      inc[2] = events.d2h_nondata_err;
      inc[3] = events.h2d_nondata_err;
      inc[4] = ready_rise || (pm_enabled && events.pm_transition);
      inc[5] = events.sig_fis_ok;
      inc[6] = events.h2d_crc_err;
      inc[7] = events.h2d_other_err;
   end

   // read clear waits for the final byte so the page shows pre-clear values;
   // only the accepting edge clears; events during a stalled end are cleared too, one on that edge counts as 1
   assign clear_all = selftest_rx ||
                      (st.phase == DONE && st.clr_after && page_ready);

   ////////////////////////////////////////////////////////////////////////////
   // counters

   generate
      for (genvar g = 0; g < phy_event_pkg::NUM_CNT; g++) begin : g_cnt
         sat_counter u_cnt (
            .core_clk (core_clk),
            .resetn   (resetn),
            .clk_en   (clk_en),
            .clear    (clear_all),
            .inc      (inc[g]),
            .value    (cnt_val[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // page byte generator

   always_comb begin
      int unsigned rel;
      int unsigned ent;
      int unsigned pos;
      logic [15:0] ident;
      logic [31:0] wide;
      rel = 0;
      ent = 0;
      pos = 0;
      ident = 16'h0000;
      wide = 32'h00000000;
      cur_byte = 8'h00;
      if (st.idx >= 10'(phy_event_pkg::HDR_BYTES) &&
          st.idx < 10'(phy_event_pkg::LIST_END)) begin
         rel = int'(st.idx) - phy_event_pkg::HDR_BYTES;
         ent = rel / phy_event_pkg::ENTRY_BYTES;
         pos = rel % phy_event_pkg::ENTRY_BYTES;
         // vendor bit 15 left clear: all counters are standard ones
         ident = {1'b0, phy_event_pkg::SIZE_CODE_32,
                  phy_event_pkg::CODE_LIST[ent]};
         // upper half all ones once the counter is pinned at maximum
         wide = {(&cnt_val[ent]) ? 16'hFFFF : 16'h0000, cnt_val[ent]};
         unique case (pos)
            0: cur_byte = ident[7:0];
            1: cur_byte = ident[15:8];
            2: cur_byte = wide[7:0];
            3: cur_byte = wide[15:8];
            4: cur_byte = wide[23:16];
            default: cur_byte = wide[31:24];
         endcase
      end
      // bytes LIST_END..TERM_END-1 are the zero terminator, then zero padding
      if (st.idx == phy_event_pkg::LAST_BYTE) begin
         cur_byte = 8'h00 - st.sum;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer

   always_comb begin
      next_st = st;
      next_st.ready_d = events.phy_ready;
      unique case (st.phase)
         IDLE: begin
            next_st.out = '0;
            if (read_req) begin
               next_st.phase = SEND;
               next_st.idx = 10'h000;
               next_st.sum = 8'h00;
               next_st.clr_after = read_clear;
            end
         end
         SEND: begin
            if (!st.out.valid || page_ready) begin
               next_st.out.valid = 1'b1;
               next_st.out.data = cur_byte;
               next_st.out.last = (st.idx == phy_event_pkg::LAST_BYTE);
               next_st.sum = st.sum + cur_byte;
               if (st.idx == phy_event_pkg::LAST_BYTE) begin
                  next_st.phase = DONE;
               end else begin
                  next_st.idx = st.idx + 10'h001;
               end
            end
         end
         DONE: begin
            if (page_ready) begin
               next_st.out = '0;
               next_st.phase = IDLE;
               next_st.clr_after = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st <= '0;
         st.phase <= IDLE;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   assign page_out = st.out;
   assign busy = (st.phase != IDLE);
endmodule
`default_nettype wire

// ---- tb/page_stream_sva.sv ----
// assertions on the log page byte stream
`timescale 1ns/100ps
`default_nettype none
module page_stream_sva (
   input wire logic                      core_clk,
   input wire logic                      resetn,
   input wire logic                      clk_en,
   input wire logic                      read_req,
   input wire logic                      page_ready,
   input wire phy_event_pkg::page_byte_t page_out,
   input wire logic                      busy
);
   logic [9:0] idx;
   logic [7:0] sum;
   logic       take;
   assign take = page_out.valid && page_ready && clk_en;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (!resetn || !busy) begin
         idx <= 10'h000;
         sum <= 8'h00;
      end else if (take) begin
         idx <= idx + 10'h001;
         sum <= sum + page_out.data;
      end
   end
   sequence start_s; !busy && read_req && clk_en; endsequence
   sequence answer_s; busy ##1 page_out.valid; endsequence
   start_ans_a: assert property (start_s |=> answer_s)
      else $error("page start late");
   hold_byte_a: assert property (page_out.valid && !page_ready |=> $stable(page_out))
      else $error("byte moved while stalled");
   page_end_a: assert property (take && page_out.last |=> !busy && !page_out.valid)
      else $error("page did not end");
   last_pos_a: assert property (page_out.valid |-> page_out.last == (idx == 10'h1FF))
      else $error("last flag misplaced");
   hdr_zero_a: assert property (page_out.valid && idx < 10'h004 |-> page_out.data == 8'h00)
      else $error("header not zero");
   tail_zero_a: assert property (page_out.valid && idx > 10'h033 && idx < 10'h1FF
      |-> page_out.data == 8'h00) else $error("tail not zero");
   id_size_a: assert property (page_out.valid && idx < 10'h034 && idx > 10'h004
      && (idx - 10'h004) % 10'h006 == 10'h001 |-> page_out.data == 8'h20) else $error("bad id");
   csum_a: assert property (take && page_out.last |-> 8'(sum + page_out.data) == 8'h00)
      else $error("bad checksum");
endmodule
bind phy_event_counter_log page_stream_sva i_page_stream_sva (.core_clk, .resetn, .clk_en,
   .read_req, .page_ready, .page_out, .busy);
`default_nettype wire

// ---- tb/host_reader.sv ----
// host side page reader, prompt or stalling
`timescale 1ns/100ps
`default_nettype none
module host_reader (
   input  wire logic core_clk,
   input  wire logic slow,
   output var logic  page_ready
);
   initial page_ready = 1'b0;
   // reads the whole page; slow mode takes one cycle in four
   always @(posedge core_clk) page_ready <= !slow || $urandom_range(3) == 0;
endmodule
`default_nettype wire

// ---- tb/phy_event_counter_log_bench.sv ----
// self-checking bench for the link event counter log unit
`timescale 1ns/100ps
`default_nettype none
module phy_event_counter_log_bench;
   logic core_clk, resetn, pm_enabled, selftest_rx, read_req, read_clear, slow, page_ready;
   logic busy, prev;
   phy_event_pkg::link_events_t events;
   phy_event_pkg::page_byte_t   page_out;
   logic [15:0] cnt [8];
   logic [8:0]  q [$];
   int          err_count, n_tests;
   phy_event_counter_log i_phy_event_counter_log (.core_clk, .resetn, .clk_en(1'b1), .events,
      .pm_enabled, .selftest_rx, .read_req, .read_clear, .page_ready, .page_out, .busy);
   host_reader i_host_reader (.core_clk, .slow, .page_ready);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   ////////////////////////////////////////
   task automatic chk(logic [8:0] seen, logic [8:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error page byte expected %h seen %h", exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic ev(phy_event_pkg::link_events_t e, logic pm, logic st);
      logic [7:0] inc;
      inc = {e.h2d_data_err, e.d2h_nondata_err | e.h2d_nondata_err, e.d2h_nondata_err,
         e.h2d_nondata_err, e.phy_ready & !prev | e.pm_transition & pm,
         e.sig_fis_ok, e.h2d_crc_err, e.h2d_other_err};
      prev = e.phy_ready;
      for (int k = 0; k < 8; k++) begin
         cnt[k] = st ? 16'(inc[7-k]) : cnt[k] + 16'(inc[7-k] && cnt[k] != 16'hFFFF);
      end
      @(posedge core_clk);
      events <= e;
      pm_enabled <= pm;
      selftest_rx <= st;
   endtask
   task automatic rnd(int n);
      for (int i = 0; i < n; i++) ev(8'($urandom), 1'($urandom), 1'b0);
   endtask
   task automatic rd(logic clr);
      logic [7:0] p [512];
      logic [7:0] s;
      int b;
      p = '{default: 8'h00};
      s = 8'h00;
      for (int k = 0; k < 8; k++) begin
         b = 4 + 6 * k;
         p[b] = phy_event_pkg::CODE_LIST[k][7:0];
         p[b+1] = {4'h2, phy_event_pkg::CODE_LIST[k][11:8]};
         {p[b+3], p[b+2]} = cnt[k];
         {p[b+5], p[b+4]} = {16{cnt[k] == 16'hFFFF}};
      end
      for (int i = 0; i < 511; i++) s += p[i];
      p[511] = -s;
      for (int i = 0; i < 512; i++) q.push_back({i == 511, p[i]});
      @(posedge core_clk);
      events <= '0;
      selftest_rx <= 1'b0;
      read_req <= 1'b1;
      read_clear <= clr;
      prev = 1'b0;
      // held a second cycle: the repeat lands while busy and must be ignored
      repeat (2) @(posedge core_clk);
      read_req <= 1'b0;
      for (int i = 0; i < 6000 && busy !== 1'b0; i++) @(negedge core_clk);
      if (clr) cnt = '{default: 16'h0000};
      chk(9'(q.size()), 9'h000);
   endtask
   always @(posedge core_clk) begin
      if (page_out.valid === 1'b1 && page_ready === 1'b1) begin
         chk({page_out.last, page_out.data}, q.size() > 0 ? q.pop_front() : 'x);
      end
   end
   initial begin
      #9000000;
      err_count++;
      end_sim;
   end
   initial begin
      void'($urandom(50));
      {resetn, pm_enabled, selftest_rx, read_req, read_clear, slow, prev} = '0;
      events = '0;
      cnt = '{default: 16'h0000};
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      rnd(300);
      rd(1'b0);
      slow <= 1'b1;
      rnd(300);
      rd(1'b1);
      rd(1'b0);
      rnd(20);
      ev(8'($urandom) | 8'hE7, 1'b1, 1'b1);
      rnd(20);
      rd(1'b0);
      slow <= 1'b0;
      for (int i = 0; i < 65540; i++) ev(8'hFF, 1'b1, 1'b0);
      rd(1'b1);
      rd(1'b0);
      end_sim;
   end
endmodule
`default_nettype wire
